/* File: include/ddmc_pkg.sv */
// package for the dual converter mode control register bank
package ddmc_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_COMM_PWR = 5'h00;
  localparam logic [4:0] ADDR_FILT_MOD = 5'h01;
  localparam logic [4:0] ADDR_DATA_IF = 5'h02;
  localparam logic [4:0] ADDR_PLL_PRESC = 5'h03;
  localparam logic [4:0] ADDR_PLL_CP = 5'h04;
  localparam logic [4:0] ADDR_I_FINE = 5'h05;
  localparam logic [4:0] ADDR_I_COARSE = 5'h06;
  localparam logic [4:0] ADDR_I_OFS_HI = 5'h07;
  localparam logic [4:0] ADDR_I_OFS_LO = 5'h08;
  localparam logic [4:0] ADDR_Q_FINE = 5'h09;
  localparam logic [4:0] ADDR_Q_COARSE = 5'h0A;
  localparam logic [4:0] ADDR_Q_OFS_HI = 5'h0B;
  localparam logic [4:0] ADDR_Q_OFS_LO = 5'h0C;
  localparam logic [4:0] ADDR_VERSION = 5'h0D;
  localparam int NUM_REGS = 13;

  // ---------------------------------------------------------------
  // field positions in register 0x00
  // ---------------------------------------------------------------
  localparam int BIT_SDIO_BIDIR = 7;
  localparam int BIT_LSB_FIRST = 6;
  localparam int BIT_SOFT_RESET = 5;
  localparam int BIT_SLEEP = 4;
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_RES_COUNT = 2;
  localparam int BIT_PLL_LOCK = 1;
  // other fields
  localparam int BIT_UNSIGNED = 7;
  localparam int BIT_ONE_PORT = 6;
  localparam int BIT_CLK_DRIVE = 5;
  localparam int BIT_EXT_CLK = 3;
  localparam int BIT_PLL_ON = 7;
  localparam int BIT_CP_PROG = 6;
  localparam int BIT_ZERO_STUFF = 3;
  localparam int BIT_REAL_MIX = 2;
  localparam int BIT_OFS_DIR = 7;

  // ---------------------------------------------------------------
  // reset values and masks of writable bits
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] MASK_COMM_PWR = 8'hDC;
  localparam logic [7:0] MASK_COARSE = 8'h0F;
  localparam logic [7:0] MASK_OFS_LO = 8'h83;
  localparam logic [7:0] MASK_PRESC = 8'h03;
  localparam logic [7:0] MASK_CP = 8'hC7;
  localparam logic [7:0] MASK_DATA_IF = 8'hE8;
  localparam logic [7:0] MASK_FILT = 8'hFC;
  // arbitrary neutral silicon version code
  localparam logic [3:0] VERSION_CODE = 4'h1;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] fine_gain;
    logic [3:0] coarse_gain;
    logic [9:0] offset;
    logic offset_to_positive;
  } ddmc_chan_t;

  typedef struct packed {
    logic sdio_bidir;
    logic lsb_first;
    logic sleep;
    logic power_down;
    logic reference_resistor_count;
    logic [1:0] interp_rate;
    logic [1:0] mod_mode;
    logic zero_stuff;
    logic real_mix;
    logic unsigned_data;
    logic one_port;
    logic clk_drive;
    logic ext_data_clk;
    logic [1:0] pll_prescale;
    logic pll_on;
    logic cp_programmed;
    logic [2:0] cp_control;
  } ddmc_ctrl_t;
endpackage

/* File: logic/ddmc_regs.sv */
// mode control register bank of a dual interpolating converter
module ddmc_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic instr_read,
  input wire logic data_phase,
  input wire logic pll_locked,
  output logic sdio_oe,
  output ddmc_pkg::ddmc_ctrl_t ctrl,
  output ddmc_pkg::ddmc_chan_t in_phase_converter,
  output ddmc_pkg::ddmc_chan_t quadrature_converter,
  output logic sleep_outputs_off,
  output logic power_down_all
);
  import ddmc_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] comm_q;
  logic [7:0] regs_q [1:NUM_REGS-1];
  logic [7:0] rdata_d;
  logic soft_reset;

  // masks the bits a register really holds
  function automatic logic [7:0] wr_mask(input logic [4:0] a);
    case (a)
      ADDR_FILT_MOD: wr_mask = MASK_FILT;
      ADDR_DATA_IF: wr_mask = MASK_DATA_IF;
      ADDR_PLL_PRESC: wr_mask = MASK_PRESC;
      ADDR_PLL_CP: wr_mask = MASK_CP;
      ADDR_I_COARSE, ADDR_Q_COARSE: wr_mask = MASK_COARSE;
      ADDR_I_OFS_LO, ADDR_Q_OFS_LO: wr_mask = MASK_OFS_LO;
      default: wr_mask = 8'hFF;
    endcase
  endfunction

  assign soft_reset = reg_wr && (reg_addr == ADDR_COMM_PWR) && reg_wdata[BIT_SOFT_RESET];

  // ---------------------------------------------------------------
  // register 0x00: never cleared by the software reset
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      comm_q <= RESET_VALUE;
    end else if (reg_wr && reg_addr == ADDR_COMM_PWR) begin
      comm_q <= reg_wdata & MASK_COMM_PWR; // reset bit not stored
    end
  end

  // ---------------------------------------------------------------
  // registers 0x01..0x0C
  // ---------------------------------------------------------------
  // a soft reset wins over nothing else: it is itself a write to 0x00
  always_ff @(posedge mclk) begin
    if (rst || soft_reset) begin
      for (int i = 1; i < NUM_REGS; i++) begin
        regs_q[i] <= RESET_VALUE;
      end
    end else if (reg_wr && reg_addr >= ADDR_FILT_MOD && reg_addr <= ADDR_Q_OFS_LO) begin
      regs_q[reg_addr] <= reg_wdata & wr_mask(reg_addr);
    end
  end

  // ---------------------------------------------------------------
  // read path, registered; unmapped addresses read zero
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == ADDR_COMM_PWR) begin
      rdata_d = comm_q; // reset bit reads zero
      rdata_d[BIT_PLL_LOCK] = regs_q[ADDR_PLL_CP][BIT_PLL_ON] & pll_locked;
    end else if (reg_addr >= ADDR_FILT_MOD && reg_addr <= ADDR_Q_OFS_LO) begin
      rdata_d = regs_q[reg_addr];
    end else if (reg_addr == ADDR_VERSION) begin
      rdata_d = {4'h0, VERSION_CODE};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= RESET_VALUE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // serial data pin direction
  // ---------------------------------------------------------------
  // input-only unless bidirectional mode is set
  assign sdio_oe = comm_q[BIT_SDIO_BIDIR] & instr_read & data_phase;

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  assign sleep_outputs_off = comm_q[BIT_SLEEP];
  assign power_down_all = comm_q[BIT_POWER_DOWN];

  always_comb begin
    ctrl.sdio_bidir = comm_q[BIT_SDIO_BIDIR];
    ctrl.lsb_first = comm_q[BIT_LSB_FIRST];
    ctrl.sleep = comm_q[BIT_SLEEP];
    ctrl.power_down = comm_q[BIT_POWER_DOWN];
    ctrl.reference_resistor_count = comm_q[BIT_RES_COUNT];
    ctrl.interp_rate = regs_q[ADDR_FILT_MOD][7:6];
    ctrl.mod_mode = regs_q[ADDR_FILT_MOD][5:4];
    ctrl.zero_stuff = regs_q[ADDR_FILT_MOD][BIT_ZERO_STUFF];
    ctrl.real_mix = regs_q[ADDR_FILT_MOD][BIT_REAL_MIX];
    ctrl.unsigned_data = regs_q[ADDR_DATA_IF][BIT_UNSIGNED];
    ctrl.one_port = regs_q[ADDR_DATA_IF][BIT_ONE_PORT];
    ctrl.clk_drive = regs_q[ADDR_DATA_IF][BIT_CLK_DRIVE];
    ctrl.ext_data_clk = regs_q[ADDR_DATA_IF][BIT_EXT_CLK];
    ctrl.pll_prescale = regs_q[ADDR_PLL_PRESC][1:0];
    ctrl.pll_on = regs_q[ADDR_PLL_CP][BIT_PLL_ON];
    ctrl.cp_programmed = regs_q[ADDR_PLL_CP][BIT_CP_PROG];
    ctrl.cp_control = regs_q[ADDR_PLL_CP][2:0];
  end

  // per-channel gain and offset
  always_comb begin
    in_phase_converter.fine_gain = regs_q[ADDR_I_FINE];
    in_phase_converter.coarse_gain = regs_q[ADDR_I_COARSE][3:0];
    in_phase_converter.offset = {regs_q[ADDR_I_OFS_HI], regs_q[ADDR_I_OFS_LO][1:0]};
    in_phase_converter.offset_to_positive = regs_q[ADDR_I_OFS_LO][BIT_OFS_DIR];
    quadrature_converter.fine_gain = regs_q[ADDR_Q_FINE];
    quadrature_converter.coarse_gain = regs_q[ADDR_Q_COARSE][3:0];
    quadrature_converter.offset = {regs_q[ADDR_Q_OFS_HI], regs_q[ADDR_Q_OFS_LO][1:0]};
    quadrature_converter.offset_to_positive = regs_q[ADDR_Q_OFS_LO][BIT_OFS_DIR];
  end
endmodule

/* File: bench/ddmc_host.sv */
// host model that issues register transfers and serial phase levels
module ddmc_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  output logic instr_read,
  output logic data_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd, instr_read, data_phase} = '0;
  end
  // one strobe per write; data is inverted once released so stale values cannot pass
  task automatic wr(logic [4:0] a, logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
    #1;
  endtask
  // read data is taken once the edge after the strobe has settled
  task automatic rd(logic [4:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // instruction direction and data phase levels from the serial side
  task automatic phase(logic ir, logic dp);
    @(posedge mclk);
    instr_read <= ir;
    data_phase <= dp;
    #1;
  endtask
endmodule

/* File: bench/ddmc_regs_monitor.sv */
// assertion checker for the mode control register bank
module ddmc_regs_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic instr_read,
  input wire logic data_phase,
  input wire logic pll_locked,
  input wire logic sdio_oe,
  input wire ddmc_pkg::ddmc_ctrl_t ctrl,
  input wire ddmc_pkg::ddmc_chan_t in_phase_converter,
  input wire ddmc_pkg::ddmc_chan_t quadrature_converter,
  input wire logic sleep_outputs_off,
  input wire logic power_down_all
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddmc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // write and read requests to register 0x00
  sequence s_wr0; reg_wr && reg_addr == ADDR_COMM_PWR; endsequence
  sequence s_rd0; reg_rd && reg_addr == ADDR_COMM_PWR; endsequence
  property p_srst; s_wr0 ##0 reg_wdata[BIT_SOFT_RESET] |=> in_phase_converter == '0 && quadrature_converter == '0; endproperty
  a_srst: assert property (p_srst) else $error("soft reset left channel state");
  property p_slp; s_wr0 |=> sleep_outputs_off == $past(reg_wdata[BIT_SLEEP]); endproperty
  a_slp: assert property (p_slp) else $error("sleep level wrong");
  property p_pdn; s_wr0 |=> power_down_all == $past(reg_wdata[BIT_POWER_DOWN]); endproperty
  a_pdn: assert property (p_pdn) else $error("power down level wrong");
  property p_sdio; sdio_oe == (ctrl.sdio_bidir && instr_read && data_phase); endproperty
  a_sdio: assert property (p_sdio) else $error("data pin direction wrong");
  property p_lock; s_rd0 |=> reg_rdata[BIT_PLL_LOCK] == ($past(pll_locked) && $past(ctrl.pll_on)) && !reg_rdata[BIT_SOFT_RESET]; endproperty
  a_lock: assert property (p_lock) else $error("lock or reset bit read wrong");
  property p_ifine; reg_wr && reg_addr == ADDR_I_FINE |=> in_phase_converter.fine_gain == $past(reg_wdata); endproperty
  a_ifine: assert property (p_ifine) else $error("in-phase fine gain wrong");
  property p_qfine; reg_wr && reg_addr == ADDR_Q_FINE |=> quadrature_converter.fine_gain == $past(reg_wdata); endproperty
  a_qfine: assert property (p_qfine) else $error("quadrature fine gain wrong");
  property p_iofs; reg_wr && reg_addr == ADDR_I_OFS_LO |=> in_phase_converter.offset[1:0] == $past(reg_wdata[1:0])
    && in_phase_converter.offset_to_positive == $past(reg_wdata[BIT_OFS_DIR]); endproperty
  a_iofs: assert property (p_iofs) else $error("in-phase offset low bits wrong");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
endmodule
bind ddmc_regs ddmc_regs_monitor mon (.*);

/* File: bench/ddmc_regs_tb_top.sv */
// self-checking bench for the mode control register bank
module ddmc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ddmc_pkg::*;
  logic mclk = 0, rst = 1, pll_locked = 0, reg_wr, reg_rd, instr_read, data_phase, sdio_oe;
  logic sleep_outputs_off, power_down_all;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  ddmc_ctrl_t ctrl;
  ddmc_chan_t in_phase_converter, quadrature_converter;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  always #4 mclk = ~mclk;
  ddmc_host host (.*);
  ddmc_regs uut (.*);
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // writable bits per address; version is read-only
  function automatic logic [7:0] msk(logic [4:0] a);
    case (a)
      ADDR_COMM_PWR: return MASK_COMM_PWR;
      ADDR_FILT_MOD: return MASK_FILT;
      ADDR_DATA_IF: return MASK_DATA_IF;
      ADDR_PLL_PRESC: return MASK_PRESC;
      ADDR_PLL_CP: return MASK_CP;
      ADDR_I_COARSE, ADDR_Q_COARSE: return MASK_COARSE;
      ADDR_I_OFS_LO, ADDR_Q_OFS_LO: return MASK_OFS_LO;
      ADDR_VERSION: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction
  // reg 0x00 goes first so its soft reset cannot wipe the later writes
  task automatic t_regs(logic [7:0] p);
    for (int a = 0; a < 14; a++) host.wr(a[4:0], p);
    for (int a = 0; a < 14; a++) begin
      host.rd(a[4:0], d);
      chk("readback", d, (p & msk(a[4:0])) | (a == 13 ? {4'h0, VERSION_CODE} : 8'h00));
    end
    chk("ctrl", {ctrl.unsigned_data, ctrl.one_port, ctrl.ext_data_clk, ctrl.reference_resistor_count,
      ctrl.zero_stuff, ctrl.real_mix, ctrl.pll_on, ctrl.cp_programmed, ctrl.lsb_first, sleep_outputs_off,
      power_down_all}, {p[7], p[6], p[3], p[2], p[3], p[2], p[7], p[6], p[6], p[4], p[3]});
    chk("ctrl misc", {ctrl.sdio_bidir, ctrl.clk_drive, ctrl.pll_prescale, ctrl.cp_control},
      {p[7], p[5], p[1:0], p[2:0]});
    chk("i gain", {in_phase_converter.fine_gain, in_phase_converter.coarse_gain}, {p, p[3:0]});
    chk("q fine", quadrature_converter.fine_gain, p);
    chk("q coarse", quadrature_converter.coarse_gain, p[3:0]);
    chk("i offset", {in_phase_converter.offset, in_phase_converter.offset_to_positive}, {p, p[1:0], p[7]});
    chk("q dir", quadrature_converter.offset_to_positive, p[7]);
  endtask
  // soft reset with sleep and power down also set in the same write
  task automatic t_soft;
    host.wr(ADDR_COMM_PWR, 8'h38);
    host.rd(ADDR_COMM_PWR, d);
    chk("reg0 kept", d, 8'h18);
    host.rd(ADDR_FILT_MOD, d);
    chk("reg1 cleared", d, 8'h00);
    chk("channels cleared", {in_phase_converter, quadrature_converter}, 64'h0);
  endtask
  // lock status only shows while the pll is enabled
  task automatic t_lock;
    host.wr(ADDR_PLL_CP, 8'h80);
    @(posedge mclk) pll_locked <= 1'b1;
    host.rd(ADDR_COMM_PWR, d);
    chk("lock on", d[1], 1'b1);
    host.wr(ADDR_PLL_CP, 8'h00);
    host.rd(ADDR_COMM_PWR, d);
    chk("lock pll off", d[1], 1'b0);
  endtask
  // every interpolation and modulation code, then pin direction
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      host.wr(ADDR_FILT_MOD, {i[1:0], i[1:0], 4'h0});
      chk("modes", {ctrl.interp_rate, ctrl.mod_mode}, {i[1:0], i[1:0]});
    end
    host.wr(ADDR_COMM_PWR, 8'h80);
    for (int i = 0; i < 4; i++) begin
      host.phase(i[1], i[0]);
      chk("sdio dir", sdio_oe, i == 3);
    end
    host.wr(ADDR_COMM_PWR, 8'h00);
    chk("sdio input only", sdio_oe, 1'b0);
    host.wr(5'h1F, 8'hFF);
    host.rd(5'h1F, d);
    chk("unmapped", d, 8'h00);
  endtask
  // main sequence; reset contents are read before any write
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 14; a++) begin
      host.rd(a[4:0], d);
      chk("reset value", d, a == 13 ? {4'h0, VERSION_CODE} : 8'h00);
    end
    t_regs(8'hFF);
    t_regs(8'h5A);
    t_soft;
    t_lock;
    t_modes;
    stop_test;
  end
  // hang guard, well above the roughly 200 cycles the run needs
  always @(posedge mclk) begin
    if (++cyc == 3000) begin
      bad_count++;
      stop_test;
    end
  end
endmodule
